// [src/charger_i2c_pkg.sv]
`default_nettype none
package charger_i2c_pkg;
    localparam longint unsigned CLK_HZ        = 40_000_000;
    localparam longint unsigned LINK_HZ_DFLT  = 66_000_000;
    localparam longint unsigned STD_BPS       = 100_000;
    localparam longint unsigned FAST_BPS      = 400_000;
    localparam int unsigned     OVERSAMPLE    = 20;
    localparam logic [6:0]      SLAVE_ADDR_DFLT = 7'h6B;

    localparam int unsigned     NUM_REGS      = 45;
    localparam logic [7:0]      FIRST_REG     = 8'h00;
    localparam logic [7:0]      LAST_REG      = 8'h2C;
    localparam logic [7:0]      OOR_BYTE      = 8'hFF;
    localparam logic [7:0]      RO_A_LO       = 8'h0A;
    localparam logic [7:0]      RO_A_HI       = 8'h11;
    localparam logic [7:0]      RO_B_LO       = 8'h17;
    localparam logic [7:0]      RO_B_HI       = 8'h24;
    localparam logic [7:0]      RO_C_LO       = 8'h26;
    localparam logic [7:0]      RO_C_HI       = 8'h27;
    localparam logic [7:0]      RO_D          = 8'h2B;

    localparam logic [7:0]      VCELL_OFFS    = 8'h00;
    localparam logic [7:0]      VCELL_RST     = 8'hA0;
    localparam logic [7:0]      ICHG_OFFS     = 8'h01;
    localparam logic [7:0]      ICHG_RST      = 8'h5E;
    localparam logic [7:0]      WD_CTRL_OFFS  = 8'h05;
    localparam logic [7:0]      WD_CTRL_RST   = 8'h10;
    localparam int unsigned     WD_KICK_BIT   = 6;
    localparam int unsigned     WD_SEL_LSB    = 4;
    localparam logic [1:0]      WD_SEL_OFF    = 2'h0;

    localparam longint unsigned INT_PULSE_NS  = 256_000;
    localparam longint unsigned INT_PULSE_CYC = (INT_PULSE_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
    localparam longint unsigned SAFETY_HOURS  = 12;
    localparam longint unsigned SAFETY_CYC    = SAFETY_HOURS * 64'd3600 * CLK_HZ;
    localparam longint unsigned WD_SHORT_S    = 40;
    localparam longint unsigned WD_MID_S      = 80;
    localparam longint unsigned WD_LONG_S     = 160;
    localparam longint unsigned WD_SHORT_CYC  = WD_SHORT_S * CLK_HZ;
    localparam longint unsigned WD_MID_CYC    = WD_MID_S * CLK_HZ;
    localparam longint unsigned WD_LONG_CYC   = WD_LONG_S * CLK_HZ;

    typedef enum logic [2:0] {L_IDLE, L_RX, L_ACK, L_WAIT, L_TX, L_RACK} link_st_t;
    typedef enum logic [1:0] {P_ADDR, P_OFFS, P_DATA} phase_t;

    function automatic logic is_writable(input logic [7:0] a);
        logic ro;
        ro = (a >= RO_A_LO && a <= RO_A_HI) || (a >= RO_B_LO && a <= RO_B_HI) ||
             (a >= RO_C_LO && a <= RO_C_HI) || (a == RO_D);
        return !ro && (a <= LAST_REG);
    endfunction

    function automatic logic [NUM_REGS-1:0][7:0] reg_defaults();
        logic [NUM_REGS-1:0][7:0] v;
        v = '0;
        v[VCELL_OFFS] = VCELL_RST;
        v[ICHG_OFFS] = ICHG_RST;
        v[WD_CTRL_OFFS] = WD_CTRL_RST;
        return v;
    endfunction
endpackage
`default_nettype wire

// [src/charger_i2c_slave_host_watchdog.sv]
`default_nettype none
module charger_i2c_slave_host_watchdog
    import charger_i2c_pkg::*;
#(
    parameter logic [6:0]  SLAVE_ADDR       = SLAVE_ADDR_DFLT,
    parameter longint unsigned LINK_HZ      = LINK_HZ_DFLT,
    parameter logic [15:0] INT_PULSE_CYCLES = 16'(INT_PULSE_CYC),
    parameter logic [41:0] SAFETY_CYCLES    = 42'(SAFETY_CYC),
    parameter logic [32:0] WD_SHORT_CYCLES  = 33'(WD_SHORT_CYC),
    parameter logic [32:0] WD_MID_CYCLES    = 33'(WD_MID_CYC),
    parameter logic [32:0] WD_LONG_CYCLES   = 33'(WD_LONG_CYC)
) (
    input  wire logic i_ref_clk,
    input  wire logic i_arst_n,
    input  wire logic i_link_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output var  logic o_scl_o,
    output var  logic o_scl_oe,
    output var  logic o_sda_o,
    output var  logic o_sda_oe,
    output var  logic o_int_n,
    output var  logic o_host_control_lapsed,
    output var  logic o_charge_enable
);
    // oversampling must resolve every fast-mode edge
    if (LINK_HZ < OVERSAMPLE * FAST_BPS || FAST_BPS < STD_BPS) begin : g_rate_chk
        $error("link clock too slow for fast-mode sampling");
    end
    if (INT_PULSE_CYCLES == 16'h0000 || WD_SHORT_CYCLES == 33'h0 || WD_MID_CYCLES == 33'h0 ||
        WD_LONG_CYCLES == 33'h0) begin : g_cnt_chk
        $error("pulse and watchdog counts must be nonzero");
    end

    // ---------------- link domain ----------------
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic       scl_f;
        logic       sda_f;
        logic [2:0] ack_s;
        logic       ack_f;
        link_st_t   st;
        phase_t     ph;
        logic [3:0] bits;
        logic [7:0] sh;
        logic       rw;
        logic       mnack;
        logic [7:0] offs;
        logic       req_t;
        logic       req_we;
        logic [7:0] req_addr;
        logic [7:0] req_wd;
        logic       sda_oe;
        logic       scl_oe;
        logic       lo;
    } link_t;

    localparam link_t LQ_RST = '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, st: L_IDLE,
                                 ph: P_ADDR, default: '0};

    // ---------------- reference domain ----------------
    typedef struct packed {
        logic [2:0]  req_s;
        logic        req_f;
        logic        stage;
        logic        oor;
        logic [7:0]  rdata;
        logic        ack_t;
        logic        host;
        logic [1:0]  wd_sel;
        logic [32:0] wd_cnt;
        logic [41:0] safe_cnt;
        logic        restore;
        logic [15:0] int_cnt;
        logic        int_n;
        logic        lapsed;
        logic        chg;
    } ref_t;

    localparam ref_t RQ_RST = '{wd_sel: WD_CTRL_RST[WD_SEL_LSB+:2], int_cnt: INT_PULSE_CYCLES,
                                int_n: 1'b0, lapsed: 1'b1, chg: 1'b1, default: '0};

    link_t lq;
    link_t ln;
    ref_t  rq;
    ref_t  rn;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       pend;
    logic       byte_end;

    logic       req_n;
    logic       go;
    logic       wr_evt;
    logic       wd_exp;
    logic       mem_we;
    logic [7:0] mem_wd;
    logic [7:0] mem_rd;

    function automatic logic [32:0] wd_limit(input logic [1:0] sel);
        case (sel)
            2'h1:    return WD_SHORT_CYCLES;
            2'h2:    return WD_MID_CYCLES;
            default: return WD_LONG_CYCLES;
        endcase
    endfunction

    always_comb begin
        ln = lq;
        ln.scl_s = {lq.scl_s[1:0], i_scl};
        ln.sda_s = {lq.sda_s[1:0], i_sda};
        ln.ack_s = {lq.ack_s[1:0], rq.ack_t};
        if (lq.scl_s[1] == lq.scl_s[2]) begin
            ln.scl_f = lq.scl_s[2];
        end
        if (lq.sda_s[1] == lq.sda_s[2]) begin
            ln.sda_f = lq.sda_s[2];
        end
        if (lq.ack_s[1] == lq.ack_s[2]) begin
            ln.ack_f = lq.ack_s[2];
        end
        scl_rise = ln.scl_f & ~lq.scl_f;
        scl_fall = ~ln.scl_f & lq.scl_f;
        start_c  = lq.scl_f & ln.scl_f & lq.sda_f & ~ln.sda_f;
        stop_c   = lq.scl_f & ln.scl_f & ~lq.sda_f & ln.sda_f;
        pend     = lq.req_t != lq.ack_f;
        byte_end = (lq.st == L_RX) && scl_fall && (lq.bits == 4'd8);
        ln.lo = 1'b0;
        if (start_c) begin
            ln.st = L_RX;
            ln.ph = P_ADDR;
            ln.bits = 4'd0;
            ln.sda_oe = 1'b0;
            ln.scl_oe = 1'b0;
        end else if (stop_c) begin
            ln.st = L_IDLE;
            ln.sda_oe = 1'b0;
            ln.scl_oe = 1'b0;
        end else begin
            case (lq.st)
                L_RX: begin
                    if (scl_rise) begin
                        ln.sh = {lq.sh[6:0], lq.sda_f};
                        ln.bits = lq.bits + 4'd1;
                    end else if (byte_end) begin
                        ln.bits = 4'd0;
                        ln.st = L_IDLE;
                        case (lq.ph)
                            P_ADDR: begin
                                if (lq.sh[7:1] == SLAVE_ADDR) begin
                                    ln.rw = lq.sh[0];
                                    ln.ph = P_OFFS;
                                    ln.sda_oe = 1'b1;
                                    ln.st = L_ACK;
                                end
                            end
                            P_OFFS: begin
                                // an undefined offset is refused outright
                                if (lq.sh <= LAST_REG) begin
                                    ln.offs = lq.sh;
                                    ln.ph = P_DATA;
                                    ln.sda_oe = 1'b1;
                                    ln.st = L_ACK;
                                end
                            end
                            default: begin
                                ln.req_we = 1'b1;
                                ln.req_addr = lq.offs;
                                ln.req_wd = lq.sh;
                                ln.req_t = ~lq.req_t;
                                ln.offs = lq.offs + 8'd1;
                                ln.sda_oe = 1'b1;
                                ln.st = L_ACK;
                            end
                        endcase
                    end
                end
                L_ACK: begin
                    if (scl_fall) begin
                        ln.sda_oe = 1'b0;
                        ln.st = L_RX;
                        if (lq.rw) begin
                            ln.req_we = 1'b0;
                            ln.req_addr = lq.offs;
                            ln.req_t = ~lq.req_t;
                            ln.offs = lq.offs + 8'd1;
                            ln.scl_oe = 1'b1;
                            ln.st = L_WAIT;
                        end else if (pend) begin
                            ln.scl_oe = 1'b1;
                            ln.st = L_WAIT;
                        end
                    end
                end
                L_WAIT: begin
                    if (!pend) begin
                        ln.scl_oe = 1'b0;
                        ln.bits = 4'd0;
                        ln.st = L_RX;
                        if (lq.rw) begin
                            ln.sh = rq.rdata;
                            ln.sda_oe = ~rq.rdata[7];
                            ln.scl_oe = 1'b1;
                            ln.st = L_TX;
                        end
                    end
                end
                L_TX: begin
                    if (lq.scl_oe) begin
                        // first bit settles a cycle before the clock is let go
                        ln.scl_oe = 1'b0;
                    end else if (scl_fall) begin
                        if (lq.bits == 4'd7) begin
                            ln.sda_oe = 1'b0;
                            ln.st = L_RACK;
                        end else begin
                            ln.sh = {lq.sh[6:0], 1'b1};
                            ln.sda_oe = ~lq.sh[6];
                            ln.bits = lq.bits + 4'd1;
                        end
                    end
                end
                L_RACK: begin
                    if (scl_rise) begin
                        ln.mnack = lq.sda_f;
                    end else if (scl_fall) begin
                        ln.st = L_IDLE;
                        if (!lq.mnack) begin
                            ln.req_we = 1'b0;
                            ln.req_addr = lq.offs;
                            ln.req_t = ~lq.req_t;
                            ln.offs = lq.offs + 8'd1;
                            ln.scl_oe = 1'b1;
                            ln.st = L_WAIT;
                        end
                    end
                end
                default: begin
                    ln.st = L_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lq <= LQ_RST;
        end else begin
            lq <= ln;
        end
    end

    // request words stay still from toggle until answer, so they cross unsynchronised
    always_comb begin
        rn = rq;
        rn.req_s = {rq.req_s[1:0], lq.req_t};
        req_n = (rq.req_s[1] == rq.req_s[2]) ? rq.req_s[2] : rq.req_f;
        rn.req_f = req_n;
        go = req_n != rq.req_f;
        wr_evt = go && lq.req_we && (lq.req_addr <= LAST_REG);
        mem_we = wr_evt && is_writable(lq.req_addr);
        mem_wd = lq.req_wd;
        if (lq.req_addr == WD_CTRL_OFFS) begin
            mem_wd[WD_KICK_BIT] = 1'b0;  // kick bit self-clears
        end
        rn.stage = go;
        if (go) begin
            rn.oor = lq.req_addr > LAST_REG;
        end
        if (rq.stage) begin
            rn.rdata = rq.oor ? OOR_BYTE : mem_rd;
            rn.ack_t = ~rq.ack_t;
        end
        rn.restore = 1'b0;
        wd_exp = 1'b0;
        if (wr_evt) begin
            rn.host = 1'b1;
            rn.wd_cnt = '0;
            rn.safe_cnt = '0;
            if (lq.req_addr == WD_CTRL_OFFS) begin
                rn.wd_sel = lq.req_wd[WD_SEL_LSB+:2];
            end
        end else if (rq.host && rq.wd_sel != WD_SEL_OFF) begin
            if (rq.wd_cnt == wd_limit(rq.wd_sel) - 33'd1) begin
                wd_exp = 1'b1;
                rn.host = 1'b0;
                rn.restore = 1'b1;
                rn.wd_sel = RQ_RST.wd_sel;
                rn.wd_cnt = '0;
                rn.safe_cnt = '0;
                rn.int_cnt = INT_PULSE_CYCLES;
            end else begin
                rn.wd_cnt = rq.wd_cnt + 33'd1;
            end
        end else if (!rq.host && rq.safe_cnt != SAFETY_CYCLES) begin
            rn.safe_cnt = rq.safe_cnt + 42'd1;
        end
        if (!wd_exp && rq.int_cnt != 16'h0000) begin
            rn.int_cnt = rq.int_cnt - 16'd1;
        end
        rn.int_n = rn.int_cnt == 16'h0000;
        rn.lapsed = ~rn.host;
        // system supply stays up; only charging halts at timer end
        rn.chg = rn.host || (rn.safe_cnt != SAFETY_CYCLES);
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rq <= RQ_RST;
        end else begin
            rq <= rn;
        end
    end

    charger_regfile #(
        .DEPTH (NUM_REGS),
        .WIDTH (8),
        .AW    (6)
    ) u_regs (
        .i_clk     (i_ref_clk),
        .i_arst_n  (i_arst_n),
        .i_restore (rq.restore),
        .i_we      (mem_we),
        .i_addr    (lq.req_addr[5:0]),
        .i_wdata   (mem_wd),
        .o_rdata   (mem_rd)
    );

    assign o_scl_o               = lq.lo;
    assign o_scl_oe              = lq.scl_oe;
    assign o_sda_o               = lq.lo;
    assign o_sda_oe              = lq.sda_oe;
    assign o_int_n               = rq.int_n;
    assign o_host_control_lapsed = rq.lapsed;
    assign o_charge_enable       = rq.chg;

    property p_addr_mismatch;
        @(posedge i_link_clk) disable iff (!i_arst_n)
        byte_end && lq.ph == P_ADDR && lq.sh[7:1] != SLAVE_ADDR |=> !lq.sda_oe && lq.st == L_IDLE;
    endproperty
    a_addr_mismatch: assert property (p_addr_mismatch) else $error("foreign address acknowledged");

    property p_offs_nack;
        @(posedge i_link_clk) disable iff (!i_arst_n)
        byte_end && lq.ph == P_OFFS && lq.sh > LAST_REG |=> !lq.sda_oe ##1 lq.st == L_IDLE || start_c;
    endproperty
    a_offs_nack: assert property (p_offs_nack) else $error("undefined offset acknowledged");

    property p_sda_chg;
        @(posedge i_link_clk) disable iff (!i_arst_n)
        $changed(lq.sda_oe) && !$past(start_c) && !$past(stop_c) |-> !lq.scl_f;
    endproperty
    a_sda_chg: assert property (p_sda_chg) else $error("data drive changed while clock high");

    property p_stretch;
        @(posedge i_link_clk) disable iff (!i_arst_n)
        $rose(lq.scl_oe) |-> lq.st == L_WAIT && !lq.scl_f;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock held outside wait");

    property p_msb;
        @(posedge i_link_clk) disable iff (!i_arst_n)
        lq.st == L_TX && scl_fall && lq.bits != 4'd7 && !start_c && !stop_c |=> lq.sda_oe == !$past(lq.sh[6]);
    endproperty
    a_msb: assert property (p_msb) else $error("transmit bit order wrong");

    property p_oor;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        go && lq.req_addr > LAST_REG |-> ##2 rq.rdata == OOR_BYTE;
    endproperty
    a_oor: assert property (p_oor) else $error("read past map not 0xFF");

    property p_host_on_write;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        wr_evt |=> !o_host_control_lapsed && o_charge_enable && rq.wd_cnt == 33'h0;
    endproperty
    a_host_on_write: assert property (p_host_on_write) else $error("write did not enter host mode");

    property p_expiry;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        wd_exp |=> o_host_control_lapsed && !o_int_n && rq.restore;
    endproperty
    a_expiry: assert property (p_expiry) else $error("expiry did not restore default mode");

    property p_int_pulse;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        $fell(o_int_n) |-> !o_int_n [*8];
    endproperty
    a_int_pulse: assert property (p_int_pulse) else $error("interrupt pulse too short");

    property p_safety;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        !rq.host && rq.safe_cnt == SAFETY_CYCLES && !wr_evt |=> !o_charge_enable;
    endproperty
    a_safety: assert property (p_safety) else $error("charging continued past safety timer");
endmodule
`default_nettype wire

// [src/charger_regfile.sv]
`default_nettype none
module charger_regfile
    import charger_i2c_pkg::*;
#(
    parameter int unsigned DEPTH = NUM_REGS,
    parameter int unsigned WIDTH = 8,
    parameter int unsigned AW    = 6
) (
    input  wire logic             i_clk,
    input  wire logic             i_arst_n,
    input  wire logic             i_restore,
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_addr,
    input  wire logic [WIDTH-1:0] i_wdata,
    output var  logic [WIDTH-1:0] o_rdata
);
    if (DEPTH != NUM_REGS || WIDTH != 8 || (1 << AW) < DEPTH) begin : g_chk
        $error("regfile shape does not match the register map");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rdata;
    } mem_state_t;

    localparam mem_state_t RST = '{mem: reg_defaults(), rdata: '0};

    mem_state_t q;
    mem_state_t d;

    always_comb begin
        d = q;
        d.rdata = (32'(i_addr) < DEPTH) ? q.mem[i_addr] : '0;
        // a write landing with the restore wins: it has already re-entered host mode
        if (i_restore) begin
            d.mem = RST.mem;
        end
        if (i_we && 32'(i_addr) < DEPTH) begin
            d.mem[i_addr] = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
endmodule
`default_nettype wire

// [tb/i2c_master_model.sv]
`default_nettype none
module i2c_master_model (
    input  wire logic i_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    int stalls = 0;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // quarter bit of 300 ns keeps each phase well over four link cycles
    task automatic q();
        repeat (12) @(negedge i_clk);
    endtask
    task automatic start();
        o_sda = 1'b1;
        q();
        o_scl = 1'b1;
        q();
        o_sda = 1'b0;
        q();
        o_scl = 1'b0;
    endtask
    task automatic stop();
        o_sda = 1'b0;
        q();
        o_scl = 1'b1;
        q();
        o_sda = 1'b1;
        q();
    endtask
    task automatic xbit(input logic b, output logic r);
        int n;
        o_sda = b;
        q();
        o_scl = 1'b1;
        // device may still hold the clock low, resume once released or after 2000 cycles
        for (n = 0; n < 2000 && i_scl !== 1'b1; n++) @(negedge i_clk);
        if (n == 2000) stalls++;
        q();
        r = i_sda;
        q();
        o_scl = 1'b0;
        q();
    endtask
    task automatic xbyte(input logic [7:0] w, input logic ack_in, output logic [7:0] r, output logic nak);
        for (int i = 7; i >= 0; i--) xbit(w[i], r[i]);
        xbit(ack_in, nak);
    endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench
    import charger_i2c_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic m_scl, m_sda, scl_oe, sda_oe, scl_o, sda_o, int_n, lapsed, chg_en;
    // a pulled line only goes low if the driven value is really 0
    wire logic scl = m_scl & (~scl_oe | scl_o);
    wire logic sda = m_sda & (~sda_oe | sda_o);
    int mismatches = 0;
    int checked = 0;
    always #12.5 i_ref_clk = ~i_ref_clk;
    initial #3.1 forever #7.5 i_link_clk = ~i_link_clk;
    charger_i2c_slave_host_watchdog #(.LINK_HZ(66_666_667), .INT_PULSE_CYCLES(16'd20), .SAFETY_CYCLES(42'd1000),
        .WD_SHORT_CYCLES(33'd10000), .WD_MID_CYCLES(33'd20000), .WD_LONG_CYCLES(33'd40000)) i_dut (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_link_clk(i_link_clk), .i_scl(scl), .i_sda(sda),
        .o_scl_o(scl_o), .o_scl_oe(scl_oe), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_int_n(int_n),
        .o_host_control_lapsed(lapsed), .o_charge_enable(chg_en));
    i2c_master_model i_master (.i_clk(i_ref_clk), .i_scl(scl), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task automatic hdr(logic [6:0] adr, logic [7:0] offs, logic exp_nak);
        logic [7:0] r;
        logic n;
        i_master.start();
        i_master.xbyte({adr, 1'b0}, 1'b1, r, n);
        i_master.xbyte(offs, 1'b1, r, n);
        chk("offset ack", 8'(exp_nak), 8'(n));
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [7:0] r;
        logic n;
        hdr(SLAVE_ADDR_DFLT, a, 1'b0);
        i_master.xbyte(d, 1'b1, r, n);
        chk("data ack", 8'h00, 8'(n));
        i_master.stop();
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e0, logic [7:0] e1);
        logic [7:0] r;
        logic n;
        hdr(SLAVE_ADDR_DFLT, a, 1'b0);
        i_master.start();
        i_master.xbyte({SLAVE_ADDR_DFLT, 1'b1}, 1'b1, r, n);
        chk("read address ack", 8'h00, 8'(n));
        i_master.xbyte(8'hFF, 1'b0, r, n);
        chk("first byte", e0, r);
        i_master.xbyte(8'hFF, 1'b1, r, n);
        chk("second byte", e1, r);
        i_master.stop();
    endtask
    task automatic t_reset();
        chk("lapsed at reset", 8'h01, 8'(lapsed));
        chk("power-up pulse", 8'h00, 8'(int_n));
        cyc(25);
        chk("pulse over", 8'h01, 8'(int_n));
        cyc(1100);
        chk("charge after safety", 8'h00, 8'(chg_en));
        $display("done reset");
    endtask
    task automatic t_map();
        rd(8'h00, 8'hA0, 8'h5E);
        rd(8'h2C, 8'h00, 8'hFF);
        hdr(7'h6A, 8'h00, 1'b1);
        i_master.stop();
        hdr(SLAVE_ADDR_DFLT, 8'h2D, 1'b1);
        i_master.stop();
        $display("done map");
    endtask
    task automatic t_host();
        int n;
        wr(8'h02, 8'h3C);
        chk("lapsed after write", 8'h00, 8'(lapsed));
        chk("charge in host", 8'h01, 8'(chg_en));
        rd(8'h02, 8'h3C, 8'h00);
        // default period select is the short one
        for (n = 0; n < 12000 && lapsed !== 1'b1; n++) @(negedge i_ref_clk);
        chk("lapsed on expiry", 8'h01, 8'(lapsed));
        if (n == 12000) give_verdict();
        chk("expiry pulse", 8'h00, 8'(int_n));
        cyc(30);
        rd(8'h02, 8'h00, 8'h00);
        $display("done host");
    endtask
    task automatic t_disable();
        wr(8'h05, 8'h50);
        rd(8'h05, 8'h10, 8'h00);
        wr(8'h0A, 8'h55);
        rd(8'h0A, 8'h00, 8'h00);
        wr(8'h05, 8'h00);
        cyc(12000);
        chk("lapsed with watchdog off", 8'h00, 8'(lapsed));
        $display("done disable");
    endtask
    task automatic give_verdict();
        mismatches += i_master.stalls;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        cyc(20);
        i_arst_n = 1'b1;
        t_reset();
        t_map();
        t_host();
        t_disable();
        give_verdict();
    end
    initial begin
        cyc(100000);
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
